// ### common/sfis_pkg.sv
// Constants shared by the sample FIFO interrupt status block
package sfis_pkg;
	// ****************************************
	// Register map and widths
	// ****************************************
	localparam int unsigned SFIS_DATA_W = 16;
	localparam int unsigned SFIS_ADDR_W = 8;
	localparam int unsigned SFIS_COUNT_W = 8;
	localparam int unsigned SFIS_THRESH_W = 6;
	localparam logic [7:0] SFIS_STATUS_ADDR = 8'h00;
	localparam logic [7:0] SFIS_MASK_ADDR = 8'h01;
	// ****************************************
	// Field positions
	// ****************************************
	localparam int unsigned SFIS_COUNT_LSB = 8;
	localparam int unsigned SFIS_FLUSH_BIT = 15;
	localparam int unsigned SFIS_RSVD_HI_BIT = 7;
	localparam int unsigned SFIS_SLOT_B_BIT = 6;
	localparam int unsigned SFIS_SLOT_A_BIT = 5;
	localparam int unsigned SFIS_RSVD_LO_W = 5;
	localparam int unsigned SFIS_FIFO_MASK_BIT = 8;
	// ****************************************
	// Reset values
	// ****************************************
	localparam logic [15:0] SFIS_MASK_RST = 16'h01ff;
	localparam logic [15:0] SFIS_ZERO16 = 16'h0000;
	localparam logic [5:0] SFIS_RSVD_RST = 6'h00;
endpackage : sfis_pkg

// ### hw/sfis_pin_drv.sv
// Interrupt pin driver with polarity and open-drain style
`timescale 1ns/1ps
module sfis_pin_drv
	import sfis_pkg::*;
(
	input wire logic core_clk,
	input wire logic nrst,
	input wire logic irq_level,
	input wire logic irq_pin_polarity,
	input wire logic irq_pin_drive_style,
	output logic irq_pin_o,
	output logic irq_pin_oe
);
	typedef struct packed {
		logic pin;
		logic oe;
	} sfis_pin_s;
	sfis_pin_s state_q;
	sfis_pin_s state_d;

	// Next pin level and enable
	always_comb
	begin
		state_d = state_q;
		state_d.pin = irq_level ^ irq_pin_polarity;
		state_d.oe = irq_pin_drive_style ? irq_level : 1'b1;
	end

	// Registered so the pin never glitches on a decode hazard
	always_ff @(posedge core_clk)
	begin
		if (!nrst)
			state_q <= '0;
		else
			state_q <= state_d;
	end

	assign irq_pin_o = state_q.pin;
	assign irq_pin_oe = state_q.oe;

	AST_PIN_POL: assert property (@(posedge core_clk) disable iff (!nrst)
		1'b1 |=> irq_pin_o == ($past(irq_level) ^ $past(irq_pin_polarity)))
		else $error("pin level does not follow polarity");
	AST_PIN_OD: assert property (@(posedge core_clk) disable iff (!nrst)
		(irq_pin_drive_style && !irq_level) |=> !irq_pin_oe)
		else $error("open drain pin driven while idle");
	AST_PIN_PP: assert property (@(posedge core_clk) disable iff (!nrst)
		(!irq_pin_drive_style) |=> irq_pin_oe)
		else $error("push pull pin not driven");
endmodule : sfis_pin_drv

// ### hw/sfis_top.sv
// Sample FIFO status, slot event flags, masks and interrupt pin
// Contract
// - Status bits 15:8 read back the number of bytes waiting in the sample FIFO.
// - The byte count is compared with the word threshold doubled, one word being two bytes.
// - Writing one to status bit 15 flushes the FIFO so its byte count drops to zero.
// - A slot B sample event sets status bit 6, which holds until the host clears it.
// - A slot A sample event sets status bit 5, which holds until the host clears it.
// - Writing one to a slot flag clears it and writing zero leaves it alone.
// - Status bit 7 and bits 4:0 are write-one-to-clear as well.
// - The FIFO threshold event interrupts only while mask bit 8 is zero, which resets to one.
// - Mask bit 6 gates the slot B event, zero enabling it, reset one.
// - Mask bit 5 gates the slot A event, zero enabling it, reset one.
// - The FIFO interrupt drops by itself once the words no longer exceed the threshold.
// - The pin is active high with polarity zero and active low with polarity one.
// - With drive style one the pin is driven only while the interrupt is asserted.
`timescale 1ns/1ps
module sfis_top
	import sfis_pkg::*;
(
	input wire logic core_clk,
	input wire logic nrst,
	input wire logic [sfis_pkg::SFIS_ADDR_W-1:0] reg_addr,
	input wire logic reg_wr,
	input wire logic [sfis_pkg::SFIS_DATA_W-1:0] reg_wdata,
	input wire logic reg_rd,
	output logic [sfis_pkg::SFIS_DATA_W-1:0] reg_rdata,
	input wire logic [sfis_pkg::SFIS_COUNT_W-1:0] fifo_byte_count,
	output logic fifo_flush,
	input wire logic [sfis_pkg::SFIS_THRESH_W-1:0] fifo_word_threshold,
	input wire logic first_slot_event,
	input wire logic second_slot_event,
	input wire logic irq_pin_polarity,
	input wire logic irq_pin_drive_style,
	output logic irq_level,
	output logic irq_pin_o,
	output logic irq_pin_oe
);
	import sfis_pkg::*;

	// ****************************************
	// State
	// ****************************************
	typedef struct packed {
		logic second_slot_event_flag;
		logic first_slot_event_flag;
		logic [5:0] rsvd_flags;
		logic [15:0] event_mask;
		logic [15:0] rdata;
		logic flush;
	} sfis_state_s;
	sfis_state_s state_q;
	sfis_state_s state_d;

	// Address match, used by both read and write decode
	function automatic logic sfis_hit(input logic [7:0] addr, input logic [7:0] reg_off);
		sfis_hit = (addr == reg_off);
	endfunction : sfis_hit

	logic wr_status;
	logic wr_mask;
	logic fifo_over;
	logic [15:0] status_view;

	assign wr_status = reg_wr && sfis_hit(reg_addr, SFIS_STATUS_ADDR);
	assign wr_mask = reg_wr && sfis_hit(reg_addr, SFIS_MASK_ADDR);

	assign fifo_over = {1'b0, fifo_byte_count} > {2'b00, fifo_word_threshold, 1'b0};

	assign status_view = {fifo_byte_count, state_q.rsvd_flags[SFIS_RSVD_LO_W],
		state_q.second_slot_event_flag, state_q.first_slot_event_flag,
		state_q.rsvd_flags[SFIS_RSVD_LO_W-1:0]};

	// ****************************************
	// Next state
	// ****************************************
	always_comb
	begin
		state_d = state_q;
		state_d.flush = 1'b0;
		if (wr_status)
		begin
			state_d.flush = reg_wdata[SFIS_FLUSH_BIT];
			if (reg_wdata[SFIS_SLOT_B_BIT])
				state_d.second_slot_event_flag = 1'b0;
			if (reg_wdata[SFIS_SLOT_A_BIT])
				state_d.first_slot_event_flag = 1'b0;
			if (reg_wdata[SFIS_RSVD_HI_BIT])
				state_d.rsvd_flags[SFIS_RSVD_LO_W] = 1'b0;
			state_d.rsvd_flags[SFIS_RSVD_LO_W-1:0] = state_q.rsvd_flags[SFIS_RSVD_LO_W-1:0]
				& ~reg_wdata[SFIS_RSVD_LO_W-1:0];
		end
		if (second_slot_event)
			state_d.second_slot_event_flag = 1'b1;
		if (first_slot_event)
			state_d.first_slot_event_flag = 1'b1;
		// Mask stored whole; reserved bits are the host's to keep
		if (wr_mask)
			state_d.event_mask = reg_wdata;
		// Read data registered; unmapped addresses read zero
		if (reg_rd)
		begin
			if (sfis_hit(reg_addr, SFIS_STATUS_ADDR))
				state_d.rdata = status_view;
			else if (sfis_hit(reg_addr, SFIS_MASK_ADDR))
				state_d.rdata = state_q.event_mask;
			else
				state_d.rdata = SFIS_ZERO16;
		end
	end

	// ****************************************
	// Registers
	// ****************************************
	always_ff @(posedge core_clk)
	begin
		if (!nrst)
		begin
			state_q.second_slot_event_flag <= 1'b0;
			state_q.first_slot_event_flag <= 1'b0;
			state_q.rsvd_flags <= SFIS_RSVD_RST;
			state_q.event_mask <= SFIS_MASK_RST;
			state_q.rdata <= SFIS_ZERO16;
			state_q.flush <= 1'b0;
		end
		else
			state_q <= state_d;
	end

	// threshold term is a live level, so it drops without a clear
	assign irq_level = (fifo_over && !state_q.event_mask[SFIS_FIFO_MASK_BIT])
		|| (state_q.second_slot_event_flag && !state_q.event_mask[SFIS_SLOT_B_BIT])
		|| (state_q.first_slot_event_flag && !state_q.event_mask[SFIS_SLOT_A_BIT]);

	assign reg_rdata = state_q.rdata;
	assign fifo_flush = state_q.flush;

	// ****************************************
	// Pin driver
	// ****************************************
	sfis_pin_drv u_pin (
		.core_clk(core_clk),
		.nrst(nrst),
		.irq_level(irq_level),
		.irq_pin_polarity(irq_pin_polarity),
		.irq_pin_drive_style(irq_pin_drive_style),
		.irq_pin_o(irq_pin_o),
		.irq_pin_oe(irq_pin_oe)
	);

	// ****************************************
	// Checks
	// ****************************************
	AST_COUNT_READ: assert property (@(posedge core_clk) disable iff (!nrst)
		(reg_rd && reg_addr == SFIS_STATUS_ADDR) |=> reg_rdata[SFIS_DATA_W-1:SFIS_COUNT_LSB] == $past(fifo_byte_count))
		else $error("status read lost byte count");
	AST_FLUSH: assert property (@(posedge core_clk) disable iff (!nrst)
		(wr_status && reg_wdata[SFIS_FLUSH_BIT]) |=> fifo_flush ##1 !fifo_flush)
		else $error("flush strobe wrong");
	AST_SET_B: assert property (@(posedge core_clk) disable iff (!nrst)
		second_slot_event |=> state_q.second_slot_event_flag)
		else $error("slot B flag not set");
	AST_SET_A: assert property (@(posedge core_clk) disable iff (!nrst)
		first_slot_event |=> state_q.first_slot_event_flag)
		else $error("slot A flag not set");
	AST_W1C_A: assert property (@(posedge core_clk) disable iff (!nrst)
		(wr_status && reg_wdata[SFIS_SLOT_A_BIT] && !first_slot_event) |=> !state_q.first_slot_event_flag)
		else $error("slot A flag not cleared");
	AST_HOLD_B: assert property (@(posedge core_clk) disable iff (!nrst)
		(state_q.second_slot_event_flag && !(wr_status && reg_wdata[SFIS_SLOT_B_BIT]))
		|=> state_q.second_slot_event_flag)
		else $error("slot B flag lost");
	AST_RSVD: assert property (@(posedge core_clk) disable iff (!nrst)
		wr_status |=> state_q.rsvd_flags == SFIS_RSVD_RST)
		else $error("reserved status bits set");
	AST_FIFO_IRQ: assert property (@(posedge core_clk) disable iff (!nrst)
		(fifo_over && !state_q.event_mask[SFIS_FIFO_MASK_BIT]) |-> irq_level)
		else $error("threshold interrupt missing");
	AST_MASK_B: assert property (@(posedge core_clk) disable iff (!nrst)
		(state_q.second_slot_event_flag && !state_q.event_mask[SFIS_SLOT_B_BIT]) |-> irq_level)
		else $error("slot B interrupt missing");
	AST_MASK_A: assert property (@(posedge core_clk) disable iff (!nrst)
		(state_q.event_mask[SFIS_FIFO_MASK_BIT] && state_q.event_mask[SFIS_SLOT_B_BIT]
		&& state_q.event_mask[SFIS_SLOT_A_BIT]) |-> !irq_level)
		else $error("masked interrupt asserted");
	AST_SLOT_A_IRQ: assert property (@(posedge core_clk) disable iff (!nrst)
		(state_q.first_slot_event_flag && !state_q.event_mask[SFIS_SLOT_A_BIT]) |-> irq_level)
		else $error("slot A interrupt missing");
	AST_AUTO_DROP: assert property (@(posedge core_clk) disable iff (!nrst)
		(!fifo_over && !state_q.second_slot_event_flag && !state_q.first_slot_event_flag) |-> !irq_level)
		else $error("interrupt stuck without source");
	COV_FLUSH: cover property (@(posedge core_clk) disable iff (!nrst) fifo_flush);
	COV_SLOT_IRQ: cover property (@(posedge core_clk) disable iff (!nrst)
		first_slot_event ##1 irq_level ##1 wr_status);
	COV_FIFO_DROP: cover property (@(posedge core_clk) disable iff (!nrst) fifo_over ##1 !fifo_over);
endmodule : sfis_top

// ### sim/sfis_host_model.sv
// Host model issuing register reads and writes to the status block
`timescale 1ns/1ps
module sfis_host_model
	import sfis_pkg::*;
(
	input wire logic core_clk,
	output logic [sfis_pkg::SFIS_ADDR_W-1:0] reg_addr,
	output logic reg_wr,
	output logic [sfis_pkg::SFIS_DATA_W-1:0] reg_wdata,
	output logic reg_rd,
	input wire logic [sfis_pkg::SFIS_DATA_W-1:0] reg_rdata
);
	// Bus idle at time zero
	initial
	begin
		reg_addr = SFIS_STATUS_ADDR;
		reg_wr = 1'h0;
		reg_wdata = SFIS_ZERO16;
		reg_rd = 1'h0;
	end
	// One-cycle strobe; stale data is inverted so a late sample shows up
	task automatic wr(input logic [7:0] a, input logic [15:0] d);
	begin
		@(posedge core_clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'h1;
		@(posedge core_clk);
		reg_wr <= 1'h0;
		reg_wdata <= ~d;
		#1;
	end
	endtask : wr
	task automatic wr_mask(input logic [2:0] m);
	begin
		wr(SFIS_MASK_ADDR, {7'h00, m[2], 1'h1, m[1], m[0], 5'h1f});
	end
	endtask : wr_mask
	// Read data is registered, so it is taken one edge after the strobe
	task automatic rd(input logic [7:0] a, output logic [15:0] d);
	begin
		@(posedge core_clk);
		reg_addr <= a;
		reg_rd <= 1'h1;
		@(posedge core_clk);
		reg_rd <= 1'h0;
		#1;
		d = reg_rdata;
	end
	endtask : rd
endmodule : sfis_host_model

// ### sim/tb_sample_fifo_interrupt_status.sv
// Self-checking bench for the sample FIFO interrupt status block
`timescale 1ns/1ps
module tb_sample_fifo_interrupt_status;
	import sfis_pkg::*;
	logic core_clk = 1'h0;
	logic nrst = 1'h0;
	logic reg_wr, reg_rd, fifo_flush, irq_level, irq_pin_o, irq_pin_oe;
	logic [7:0] reg_addr;
	logic [15:0] reg_wdata, reg_rdata, d;
	logic [7:0] fifo_byte_count = 8'h00;
	logic [5:0] fifo_word_threshold = 6'h00;
	logic [1:0] slot_ev = 2'h0;
	logic pol = 1'h0;
	logic sty = 1'h0;
	int n_mismatch = 0, total_checks = 0, cyc = 0, cnt = 0, th = 0, fl = 0, mk = 7, j;
	int unsigned seed;
	sfis_host_model i_host (.core_clk(core_clk), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata),
		.reg_rd(reg_rd), .reg_rdata(reg_rdata));
	sfis_top i_dut (.core_clk(core_clk), .nrst(nrst), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata),
		.reg_rd(reg_rd), .reg_rdata(reg_rdata), .fifo_byte_count(fifo_byte_count), .fifo_flush(fifo_flush),
		.fifo_word_threshold(fifo_word_threshold), .first_slot_event(slot_ev[0]), .second_slot_event(slot_ev[1]),
		.irq_pin_polarity(pol), .irq_pin_drive_style(sty), .irq_level(irq_level), .irq_pin_o(irq_pin_o),
		.irq_pin_oe(irq_pin_oe));
	// 10 MHz clock
	always #50 core_clk = ~core_clk;
	// ****************************************
	// Reference model and helpers
	// ****************************************
	// Threshold is in words, so the byte count is compared with twice it
	function automatic logic exp_irq();
		return ((fl & 1) != 0 && (mk & 1) == 0) || ((fl & 2) != 0 && (mk & 2) == 0) || (cnt > 2 * th && (mk & 4) == 0);
	endfunction : exp_irq
	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
	begin
		total_checks++;
		if (seen !== exp)
		begin
			n_mismatch++;
			$display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
		end
	end
	endtask : chk
	task automatic report_and_stop();
	begin
		$display("checks %0d mismatches %0d", total_checks, n_mismatch);
		if (n_mismatch == 0 && total_checks > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	end
	endtask : report_and_stop
	// Status read and interrupt level compared with the model
	task automatic step_check();
	begin
		i_host.rd(SFIS_STATUS_ADDR, d);
		chk(d, 16'(cnt * 256 + (fl & 2) * 32 + (fl & 1) * 32));
		chk({15'h0, irq_level}, {15'h0, exp_irq()});
	end
	endtask : step_check
	task automatic drive();
	begin
		@(posedge core_clk);
		fifo_byte_count <= cnt[7:0];
		fifo_word_threshold <= th[5:0];
		#1;
	end
	endtask : drive
	task automatic pulse(input int k);
	begin
		@(posedge core_clk);
		slot_ev <= 2'(1 << k);
		@(posedge core_clk);
		slot_ev <= 2'h0;
		fl = fl | (1 << k);
		#1;
	end
	endtask : pulse
	// Hang guard, well above the hundred or so cycles the run needs
	always @(posedge core_clk)
	begin
		cyc++;
		if (cyc == 3000)
		begin
			n_mismatch++;
			report_and_stop();
		end
	end
	// Main sequence
	initial
	begin
		seed = $urandom(91785);
		repeat (12) @(posedge core_clk);
		nrst <= 1'h1;
		i_host.rd(SFIS_MASK_ADDR, d);
		chk(d, 16'h01ff);
		cnt = $urandom_range(255);
		drive();
		step_check();
		// Each slot: masked, unmasked, write of zero, write of one
		for (j = 0; j < 2; j++)
		begin
			pulse(j);
			step_check();
			mk = 7 - (1 << j);
			i_host.wr_mask(mk[2:0]);
			step_check();
			i_host.wr(SFIS_STATUS_ADDR, 16'h009f);
			step_check();
			i_host.wr(SFIS_STATUS_ADDR, 16'h0020 << j);
			fl = 0;
			step_check();
		end
		// Event and clear land on one edge: the set must win
		fork
			i_host.wr(SFIS_STATUS_ADDR, 16'h0020);
			pulse(0);
		join
		step_check();
		i_host.wr(SFIS_STATUS_ADDR, 16'h0020);
		fl = 0;
		step_check();
		// Count straddles twice the threshold, so the level rises and falls alone
		mk = 3;
		i_host.wr_mask(3'h3);
		for (j = 0; j < 8; j++)
		begin
			th = $urandom_range(63);
			cnt = (j < 6) ? 2 * th + j % 2 : $urandom_range(255);
			drive();
			chk({15'h0, irq_level}, {15'h0, exp_irq()});
		end
		i_host.wr(SFIS_STATUS_ADDR, 16'h8000);
		chk({15'h0, fifo_flush}, 16'h0001);
		@(posedge core_clk);
		#1;
		chk({15'h0, fifo_flush}, 16'h0000);
		cnt = 0;
		drive();
		step_check();
		// Every polarity and drive style, interrupt both on and off
		cnt = 200;
		drive();
		for (j = 0; j < 8; j++)
		begin
			mk = (j & 4) ? 7 : 3;
			i_host.wr_mask(mk[2:0]);
			@(posedge core_clk);
			pol <= j[0];
			sty <= j[1];
			repeat (2) @(posedge core_clk);
			#1;
			chk({15'h0, irq_pin_oe}, {15'h0, !j[1] || exp_irq()});
			if (!j[1] || exp_irq())
				chk({15'h0, irq_pin_o}, {15'h0, exp_irq() ^ j[0]});
		end
		report_and_stop();
	end
endmodule : tb_sample_fifo_interrupt_status
